// ---- hdl/host_port_consts.vh ----
// Constants for the host-side controller of the parallel register port.
// Assumes a 25 MHz core clock; times are given in ns and converted to cycles, except the ack timeout, which is given in cycles.
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
`define CLK_PERIOD_NS 40
`define BUS_SEPARATE 2'h0
`define BUS_DIRSTROBE 2'h1
`define CS_TO_STROBE_SEP_NS 10
`define CS_TO_STROBE_DIR_NS 65
`define STROBE_WIDTH_NS 90
`define ACK_MAX_NS 90
`define CS_TO_STROBE_SEP_CYC ((`CS_TO_STROBE_SEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_TO_STROBE_DIR_CYC ((`CS_TO_STROBE_DIR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_WIDTH_CYC ((`STROBE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_TIMEOUT_CYC 8'h10
`define ADDR_CHAN_LAST 8'h7F
`define ADDR_GLOBAL_FIRST 8'h80
`define ADDR_GLOBAL_LAST 8'h8E
`define ADDR_GLOBAL_EXTRA 8'hC0
`define ADDR_TEST_FIRST 8'h8F
`define ADDR_TEST_LAST 8'hFD
`define ADDR_PART_ID 8'hFE
`define ADDR_REV_ID 8'hFF
`define REGION_CHANNEL 3'h0
`define REGION_GLOBAL 3'h1
`define REGION_TEST 3'h2
`define REGION_ID 3'h3
`endif

// ---- hdl/pin_sync.v ----
// Two-flop synchroniser for a single asynchronous pin level.
// Assumes the input is a level from outside the core_clk domain.
module pin_sync (
    input wire core_clk,
    input wire rstn,
    input wire reset_level,
    input wire pin_in,
    output wire level_out
);
    reg stage1_reg;
    reg stage2_reg;

    always @(posedge core_clk) begin
        if (!rstn) begin
            stage1_reg <= reset_level;
            stage2_reg <= reset_level;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign level_out = stage2_reg;
endmodule

// ---- hdl/host_port_master.v ----
// Host-side controller driving the device's asynchronous 8-bit register port.
// Assumes a single user request at a time and that the device answers on its acknowledge pin.
//
// Contract
// R1 - Bus type code selects strobe personality
// R2 - Host drives register address every access
// R3 - Chip select low while address presented
// R4 - Separate mode: address strobe high then low
// R5 - Address strobe may stay high instead
// R6 - Read strobe low enables device drivers
// R7 - Device acknowledges read with valid data
// R8 - Separate mode acknowledge within 90 ns; the code flags a timeout only after 16 cycles (640 ns)
// R9 - Release read strobe after ack, sampled data
// R10 - Write data on bus before strobe
// R11 - Write strobe low makes device receive
// R12 - Device stores write then acknowledges
// R13 - Direction mode: address strobe falls, latched
// R14 - Direction set before data strobe falls
// R15 - Device starts transfer on strobe fall
// R16 - Direction mode acknowledge within 90 ns; the code flags a timeout only after 16 cycles (640 ns)
// R17 - Raise data strobe after acknowledge seen
// R18 - Acknowledge is active low completion
// R19 - Eight channels, sixteen registers each
// R20 - Global registers 0x80-0x8E and global_control_extra
// R21 - Remaining 0x8F-0xFD are test registers
// R22 - Top two addresses are read-only identity
// R23 - Device releases ack and bus after strobe
`include "host_port_consts.vh"

module host_port_master (
    input wire core_clk,
    input wire rstn,
    input wire [1:0] host_bus_type_select,
    input wire addr_strobe_tied_high,
    input wire req_valid,
    input wire req_write,
    input wire [7:0] req_addr,
    input wire [7:0] req_wdata,
    output wire req_ready,
    output reg resp_valid,
    output reg [7:0] resp_rdata,
    output reg resp_error,
    output reg [2:0] resp_region,
    output reg [7:0] port_addr,
    output reg chip_select_n,
    output reg address_capture_strobe,
    output reg read_or_data_strobe_n,
    output reg write_or_direction,
    output reg [7:0] data_out,
    output reg data_oe,
    input wire [7:0] data_in,
    input wire transfer_acknowledge_n
);
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_SETUP = 7'h02;
    localparam [6:0] ST_LATCH = 7'h04;
    localparam [6:0] ST_STROBE = 7'h08;
    localparam [6:0] ST_WAIT = 7'h10;
    localparam [6:0] ST_RELEASE = 7'h20;
    localparam [6:0] ST_DONE = 7'h40;
    localparam integer SEP_SETUP_N = `CS_TO_STROBE_SEP_CYC;
    localparam integer DIR_SETUP_N = `CS_TO_STROBE_DIR_CYC;
    localparam integer MIN_WIDTH_N = `STROBE_WIDTH_CYC;
    localparam [7:0] SEP_SETUP = SEP_SETUP_N[7:0];
    localparam [7:0] DIR_SETUP = DIR_SETUP_N[7:0];
    localparam [7:0] MIN_WIDTH = MIN_WIDTH_N[7:0];

    reg [6:0] state_reg;
    reg [7:0] count_reg;
    reg write_reg;
    reg [7:0] wdata_reg;
    reg dir_mode_reg;
    wire ack_sync_n;
    wire [7:0] data_sync;
    genvar i;

    // Device-decoded address region, tracked here so software learns what it hit
    function [2:0] region_of;
        input [7:0] a;
        begin
            if (a <= `ADDR_CHAN_LAST)
                region_of = `REGION_CHANNEL; // [R19]
            else if ((a >= `ADDR_GLOBAL_FIRST && a <= `ADDR_GLOBAL_LAST) || a == `ADDR_GLOBAL_EXTRA)
                region_of = `REGION_GLOBAL; // [R20]
            else if (a >= `ADDR_TEST_FIRST && a <= `ADDR_TEST_LAST)
                region_of = `REGION_TEST; // [R21]
            else
                region_of = `REGION_ID; // [R22]
        end
    endfunction

    // Shared step for every wait counter; the timeout stops it long before it wraps
    function [7:0] bump;
        input [7:0] c;
        begin
            bump = c + 8'h01;
        end
    endfunction

    // Ack resets to its idle high level so reset never looks like a completion
    pin_sync ack_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .reset_level(1'b1),
        .pin_in(transfer_acknowledge_n),
        .level_out(ack_sync_n)
    );

    // Data is stable once ack is seen, so per-bit sync is safe here
    generate
        for (i = 0; i < 8; i = i + 1) begin : gen_data_sync
            pin_sync data_bit_sync (
                .core_clk(core_clk),
                .rstn(rstn),
                .reset_level(1'b0),
                .pin_in(data_in[i]),
                .level_out(data_sync[i])
            );
        end
    endgenerate

    assign req_ready = (state_reg == ST_IDLE);

    always @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            count_reg <= 8'h00;
            write_reg <= 1'b0;
            wdata_reg <= 8'h00;
            dir_mode_reg <= 1'b0;
            resp_valid <= 1'b0;
            resp_rdata <= 8'h00;
            resp_error <= 1'b0;
            resp_region <= 3'h0;
            port_addr <= 8'h00;
            chip_select_n <= 1'b1;
            address_capture_strobe <= 1'b0;
            read_or_data_strobe_n <= 1'b1;
            write_or_direction <= 1'b1;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (req_valid) begin
                        dir_mode_reg <= (host_bus_type_select == `BUS_DIRSTROBE); // [R1]
                        write_reg <= req_write;
                        wdata_reg <= req_wdata;
                        resp_region <= region_of(req_addr);
                        port_addr <= req_addr; // [R2]
                        chip_select_n <= 1'b0; // [R3]
                        // Address strobe raised first; held high if the host has none
                        address_capture_strobe <= 1'b1; // [R4] [R5]
                        count_reg <= 8'h00;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (!addr_strobe_tied_high)
                        address_capture_strobe <= 1'b0; // [R4] [R13]
                    if (write_reg) begin
                        data_out <= wdata_reg; // [R10]
                        data_oe <= 1'b1;
                    end
                    // Direction line doubles as write strobe in separate mode
                    write_or_direction <= dir_mode_reg ? ~write_reg : 1'b1; // [R14]
                    count_reg <= bump(count_reg);
                    state_reg <= ST_LATCH;
                end
                ST_LATCH: begin
                    // Wait out chip-select-to-strobe setup for the chosen personality
                    if (count_reg >= (dir_mode_reg ? DIR_SETUP : SEP_SETUP)) begin
                        if (dir_mode_reg || !write_reg)
                            read_or_data_strobe_n <= 1'b0; // [R6] [R15]
                        else
                            write_or_direction <= 1'b0; // [R11]
                        count_reg <= 8'h00;
                        state_reg <= ST_STROBE;
                    end else begin
                        count_reg <= bump(count_reg);
                    end
                end
                ST_STROBE: begin
                    count_reg <= bump(count_reg);
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    // Hold strobe for minimum width and until ack; timeout flags a dead device
                    count_reg <= bump(count_reg);
                    if (!ack_sync_n && count_reg >= MIN_WIDTH) begin // [R7] [R12] [R18]
                        resp_rdata <= write_reg ? 8'h00 : data_sync; // [R9]
                        resp_error <= 1'b0;
                        read_or_data_strobe_n <= 1'b1; // [R9] [R17]
                        write_or_direction <= 1'b1;
                        state_reg <= ST_RELEASE;
                    end else if (count_reg >= `ACK_TIMEOUT_CYC) begin // [R8] [R16]
                        resp_rdata <= 8'h00;
                        resp_error <= 1'b1;
                        read_or_data_strobe_n <= 1'b1;
                        write_or_direction <= 1'b1;
                        state_reg <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    // Select drops a cycle after the strobe so the device never sees a cut cycle
                    chip_select_n <= 1'b1;
                    data_oe <= 1'b0;
                    address_capture_strobe <= 1'b0;
                    state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    // Wait for the device to drop its ack before a new cycle
                    if (ack_sync_n) begin // [R23]
                        resp_valid <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- tb/host_port_master_chk.sv ----
// Pin checks on the register port controller.
// Assumes bus type and tie-off stay steady during an access.
module host_port_master_chk (
    input wire logic core_clk, input wire logic rstn,
    input wire logic [1:0] host_bus_type_select,
    input wire logic addr_strobe_tied_high, input wire logic [7:0] port_addr,
    input wire logic chip_select_n, input wire logic address_capture_strobe,
    input wire logic read_or_data_strobe_n, input wire logic write_or_direction,
    input wire logic data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire dm = host_bus_type_select == 2'h1;
    wire on = !chip_select_n;
    sequence s_fall; $fell(read_or_data_strobe_n); endsequence
    sequence s_latch; address_capture_strobe ##1 !address_capture_strobe; endsequence
    property p_addr; on && !$past(chip_select_n) |-> $stable(port_addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_cs; s_fall |-> !$past(chip_select_n) && (!dm || !$past(chip_select_n, 2)); endproperty
    a_cs: assert property (p_cs) else $error("select setup short");
    property p_latch; $fell(chip_select_n) && !addr_strobe_tied_high |-> s_latch; endproperty
    a_latch: assert property (p_latch) else $error("no latch pulse");
    property p_tied; on && addr_strobe_tied_high |-> address_capture_strobe; endproperty
    a_tied: assert property (p_tied) else $error("latch not high");
    property p_rd; !read_or_data_strobe_n && (!dm || write_or_direction) |-> !data_oe; endproperty
    a_rd: assert property (p_rd) else $error("host drives on read");
    property p_width; s_fall |-> !read_or_data_strobe_n [*3]; endproperty
    a_width: assert property (p_width) else $error("strobe too short");
    property p_dir; (s_fall and dm) |-> $stable(write_or_direction) && (write_or_direction || data_oe); endproperty
    a_dir: assert property (p_dir) else $error("direction or data late");
    property p_end; $rose(chip_select_n) |-> $past(read_or_data_strobe_n) && $past(write_or_direction); endproperty
    a_end: assert property (p_end) else $error("select left before strobe");
endmodule

bind host_port_master host_port_master_chk chk_u (.core_clk, .rstn, .host_bus_type_select,
    .addr_strobe_tied_high, .port_addr, .chip_select_n, .address_capture_strobe, .read_or_data_strobe_n,
    .write_or_direction, .data_oe);

// ---- tb/port_device_model.sv ----
// Device behind the port: byte map, identity bytes, acknowledge.
// Assumes it sees the controller pins directly; paced by core_clk.
module port_device_model #(parameter logic [7:0] PART_ID = 8'h3C, parameter logic [7:0] REV_ID = 8'h01) (
    input wire logic core_clk, input wire logic [1:0] host_bus_type_select, input wire logic [4:0] ack_delay,
    input wire logic chip_select_n, input wire logic address_capture_strobe,
    input wire logic read_or_data_strobe_n, input wire logic write_or_direction,
    input wire logic [7:0] port_addr, input wire logic [7:0] data_out, input wire logic data_oe,
    output wire logic [7:0] data_in, output logic transfer_acknowledge_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] held = 8'h00, last = 8'h00;
    logic [4:0] cnt = 5'h00;
    wire st = !read_or_data_strobe_n, dir = write_or_direction, dm = host_bus_type_select == 2'h1;
    wire rd = dm ? st && dir : st;
    wire wr = dm ? st && !dir : !dir;
    wire act = !chip_select_n && (rd || wr);
    wire [7:0] a = address_capture_strobe ? port_addr : held;
    wire [7:0] rv = (a == 8'hFE) ? PART_ID : (a == 8'hFF) ? REV_ID : mem[a];
    // Released bus toggles so a stale byte never passes
    assign data_in = data_oe ? data_out : (act && rd) ? rv : ~last;
    initial transfer_acknowledge_n = 1'b1;
    always @(negedge address_capture_strobe) held <= port_addr;
    always @(posedge core_clk) begin
        cnt <= act ? cnt + 5'h01 : 5'h00;
        if (act && wr && cnt == ack_delay && a < 8'hFE) mem[a] <= data_out;
        transfer_acknowledge_n <= !(act && cnt >= ack_delay);
        last <= data_in;
    end
endmodule

// ---- tb/tb_host_port_master.sv ----
// Self-checking bench: controller against the device model.
// Assumes the design and its constants header are compiled first.
`define CHECK(w, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", w, e, g); end end
module tb_host_port_master;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID_P = 8'h3C, ID_R = 8'h01; // Arbitrary values
    localparam logic [7:0] AD [7] = '{8'h00, 8'h7F, 8'h80, 8'h8E, 8'hC0, 8'h8F, 8'hFD};
    logic core_clk = 1'b0, rstn = 1'b0, addr_strobe_tied_high = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0] host_bus_type_select = 2'h0;
    logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, rd;
    logic [4:0] ack_delay = 5'h00;
    wire req_ready, resp_valid, resp_error, chip_select_n, address_capture_strobe, read_or_data_strobe_n;
    wire write_or_direction, data_oe, transfer_acknowledge_n;
    wire [7:0] resp_rdata, port_addr, data_out, data_in;
    wire [2:0] resp_region;
    int bad_count = 0, comparisons = 0;
    host_port_master dut_u (.core_clk, .rstn, .host_bus_type_select, .addr_strobe_tied_high, .req_valid,
        .req_write, .req_addr, .req_wdata, .req_ready, .resp_valid, .resp_rdata, .resp_error, .resp_region,
        .port_addr, .chip_select_n, .address_capture_strobe, .read_or_data_strobe_n, .write_or_direction,
        .data_out, .data_oe, .data_in, .transfer_acknowledge_n);
    port_device_model #(.PART_ID(ID_P), .REV_ID(ID_R)) dev_u (.core_clk, .host_bus_type_select, .ack_delay,
        .chip_select_n, .address_capture_strobe, .read_or_data_strobe_n, .write_or_direction, .port_addr,
        .data_out, .data_oe, .data_in, .transfer_acknowledge_n);
    initial forever #20 core_clk = ~core_clk;
    function automatic logic [2:0] region_of(input logic [7:0] a);
        if (a <= 8'h7F) return 3'h0;
        if (a <= 8'h8E || a == 8'hC0) return 3'h1;
        return (a >= 8'hFE) ? 3'h3 : 3'h2;
    endfunction
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(negedge core_clk);
        `CHECK("ready", 1'b1, req_ready)
        @(posedge core_clk);
        req_valid <= 1'b0;
        do begin
            @(negedge core_clk);
            n++;
            if (n == 1) `CHECK("busy", 1'b0, req_ready)
        end while (resp_valid !== 1'b1 && n < 64);
        if (resp_valid !== 1'b1) begin
            bad_count++;
            $display("BAD resp_valid exp 1 got %b", resp_valid);
            tally_and_finish;
        end else begin
            rd = resp_rdata;
        end
    endtask
    task automatic t_modes;
        logic [7:0] d;
        // Bus codes 0-2, tie-off and ack speed switched together, over the channel, global and test region boundaries
        for (int m = 0; m < 6; m++) begin
            @(posedge core_clk);
            host_bus_type_select <= 2'(m / 2);
            addr_strobe_tied_high <= m[0];
            ack_delay <= 5'(m % 2);
            for (int k = 0; k < 7; k++) begin
                d = AD[k] ^ 8'(m * 37);
                access(1'b1, AD[k], d);
                access(1'b0, AD[k], 8'h00);
                `CHECK("readback", d, rd)
                `CHECK("region", region_of(AD[k]), resp_region)
                `CHECK("error", 1'b0, resp_error)
            end
        end
        $display("test modes done");
    endtask
    task automatic t_ident;
        access(1'b1, 8'hFE, ~ID_P);
        access(1'b0, 8'hFE, 8'h00);
        `CHECK("part id", ID_P, rd)
        access(1'b0, 8'hFF, 8'h00);
        `CHECK("revision", ID_R, rd)
        `CHECK("id region", 3'h3, resp_region)
        $display("test ident done");
    endtask
    task automatic t_timeout;
        // A silent device must not hang the port
        @(posedge core_clk);
        ack_delay <= 5'h1F;
        access(1'b0, 8'h05, 8'h00);
        `CHECK("timeout flag", 1'b1, resp_error)
        `CHECK("timeout data", 8'h00, rd)
        @(posedge core_clk);
        ack_delay <= 5'h00;
        access(1'b0, 8'h00, 8'h00);
        `CHECK("recovered", 8'hB9, rd)
        $display("test timeout done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        t_modes;
        t_ident;
        t_timeout;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        tally_and_finish;
    end
endmodule
